// ==== logic/hae_params.svh ====
// offsets, field positions, reset values and counts of the halt/analyse/error control block
// assumes 32-bit AHB-Lite data and byte addresses decoded on haddr[7:0]
`ifndef HAE_PARAMS_SVH
`define HAE_PARAMS_SVH

`define HAE_OFF_STATUS    8'h00
`define HAE_OFF_CTRL      8'h04
`define HAE_OFF_HALT_IP   8'h08
`define HAE_OFF_HALT_WD   8'h0c
`define HAE_OFF_BOOT_IP   8'h10
`define HAE_OFF_BOOT_WP   8'h14
`define HAE_OFF_BOOT_LINK 8'h18

`define HAE_CTRL_SET_FAULT 0
`define HAE_CTRL_CLR_FAULT 1
`define HAE_CTRL_HOF       2
`define HAE_CTRL_J0        3

`define HAE_USER_MEM_BASE  32'h80000070
`define HAE_ROM_BOOT_ADDR  32'h7ffffffe
`define HAE_ZERO_WORD      32'h00000000

`define HAE_HALT_SLICES    2'h3
`define HAE_INIT_REFRESH   4'h8
`define HAE_IP_FAULT_STEP  32'h00000002
`define HAE_IP_HALT_STEP   32'h00000001

`endif

// ==== logic/hae_pkg.sv ====
// types shared by the halt/analyse/error control block
// assumes hae_params.svh supplies all numeric constants
package hae_pkg;

  typedef enum logic [3:0] {
    ST_RESET     = 4'h0,
    ST_MEMCFG    = 4'h1,
    ST_REFRESH   = 4'h2,
    ST_AWAIT_LOW = 4'h3,
    ST_BOOT      = 4'h4,
    ST_WAIT_LINK = 4'h5,
    ST_RUN       = 4'h6,
    ST_HALT_PEND = 4'h7,
    ST_HALTED    = 4'h8
  } hae_state_t;

  typedef struct packed {
    logic ovf;
    logic div0;
    logic bounds;
    logic fpu;
  } hae_fault_src_t;

  typedef struct packed {
    logic fault;
    logic hof;
  } hae_flags_t;

  typedef struct packed {
    logic [3:0] in_busy;
    logic [3:0] out_busy;
  } hae_link_stat_t;

endpackage : hae_pkg

// ==== logic/hae_sync.sv ====
// three-stage pin synchroniser; an output bit changes once stages two and three agree
// assumes the pins are asynchronous to mclk; no reset so levels survive a reset pulse
module hae_sync #(
  parameter int W = 3
) (
  // clock
  input  wire logic         mclk,
  // pins and synchronised levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge mclk)
  begin
    s1_r <= pin_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // disagreeing bits hold their last settled value
  always_ff @(posedge mclk)
  begin
    level_out <= (s2_r & ~(s2_r ^ s3_r)) | (level_out & (s2_r ^ s3_r));
  end

endmodule : hae_sync

// ==== logic/hae_flag_stack.sv ====
// save slot for fault and halt-on-fault flags across a high-priority pre-emption
// assumes pre-emption does not nest: only a low-priority process is pre-empted
module hae_flag_stack
  import hae_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // pre-emption events
  input  wire logic       preempt_start,
  input  wire logic       preempt_end,
  // live flags and saved copy
  input  hae_flags_t      live_flags,
  output hae_flags_t      saved_flags,
  output logic            restore
);

  logic held_r;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      held_r <= 1'b0;
    else if (preempt_start)
      held_r <= 1'b1;
    else if (preempt_end)
      held_r <= 1'b0;
  end

  // saved value is also what the high-priority process starts with
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      saved_flags <= '0;
    else if (preempt_start)
      saved_flags <= live_flags;
  end

  assign restore = preempt_end && held_r;

endmodule : hae_flag_stack

// ==== logic/hae_ctrl.sv ====
// halt, analyse and error-signalling control with an AHB-Lite register slave
// assumes the core signals descheduling points, time-slice ticks and fault causes on mclk
//
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`include "hae_params.svh"

module hae_ctrl
  import hae_pkg::*;
(
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           rstn,
  // AHB-Lite slave
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic                hresp,
  output logic [31:0]         hrdata,
  // pins
  input  wire logic           analyse_halt,
  input  wire logic           fault_chain_input,
  input  wire logic           boot_source_select,
  output logic                err_out,
  // core
  input  wire logic           desched_point,
  input  wire logic           timeslice_tick,
  input  wire logic           hipri_active,
  input  wire logic [31:0]    instr_ip,
  input  wire logic [31:0]    core_wp,
  input  wire logic           core_pri,
  input  hae_fault_src_t      fault_src,
  input  wire logic           preempt_start,
  input  wire logic           preempt_end,
  output logic                proc_run,
  output logic                halted,
  output logic                jump_zero_break_enable,
  output logic                boot_go,
  output logic [31:0]         boot_ip,
  output logic [31:0]         boot_wp,
  output logic [31:0]         stack_a,
  output logic [31:0]         stack_b,
  output logic [31:0]         stack_c,
  // memory interface
  output logic                memcfg_start,
  input  wire logic           memcfg_done,
  output logic                init_refresh,
  input  wire logic           refresh_done,
  output logic                refresh_en,
  // links
  input  hae_link_stat_t      link_stat,
  input  wire logic           link_boot_done,
  input  wire logic [1:0]     link_boot_id,
  input  wire logic [31:0]    link_boot_len,
  output logic                link_out_fetch_en,
  output logic                link_shutdown
);

  hae_state_t state_r;
  logic [2:0] pins_s;
  logic       analyse_s;
  logic       chain_s;
  logic       bootsel_s;
  logic       analyse_rst_r;
  logic       fault_r;
  logic       hof_r;
  logic       j0_r;
  logic       cause_fault_r;
  logic       cfg_valid_r;
  logic [1:0] slice_cnt_r;
  logic [3:0] refresh_cnt_r;
  logic [31:0] halt_ip_r;
  logic [31:0] halt_wd_r;
  logic [1:0] boot_link_r;
  logic       boot_rom_r;
  hae_flags_t saved_flags;
  logic       restore;
  // bus pipeline
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  logic       ctrl_wr;
  logic       addr_phase;
  logic [31:0] rd_word;
  // derived events
  logic       running;
  logic       fault_set;
  logic       fault_clr;
  logic       halt_fault;
  logic       slice_timeout;
  logic [31:0] link_wp;

  hae_sync #(.W(3)) u_sync (
    .mclk      (mclk),
    .pin_in    ({analyse_halt, fault_chain_input, boot_source_select}),
    .level_out (pins_s)
  );

  assign analyse_s = pins_s[2];
  assign chain_s   = pins_s[1];
  assign bootsel_s = pins_s[0];

  hae_flag_stack u_stack (
    .mclk          (mclk),
    .rstn          (rstn),
    .preempt_start (preempt_start),
    .preempt_end   (preempt_end),
    .live_flags    ({fault_r, hof_r}),
    .saved_flags   (saved_flags),
    .restore       (restore)
  );

  assign running    = (state_r == ST_RUN) || (state_r == ST_HALT_PEND);
  assign addr_phase = hsel && htrans[1] && hready;
  assign ctrl_wr    = wr_pend_r && (wr_addr_r == `HAE_OFF_CTRL);
  assign fault_set  = (running && (|fault_src)) ||
                      (ctrl_wr && hwdata[`HAE_CTRL_SET_FAULT]);
  assign fault_clr  = ctrl_wr && hwdata[`HAE_CTRL_CLR_FAULT];
  // only a clear-to-set edge with halt-on-fault already set halts
  assign halt_fault = running && fault_set && !fault_r && hof_r;
  assign slice_timeout = timeslice_tick && !hipri_active &&
                         (slice_cnt_r == `HAE_HALT_SLICES - 2'h1);
  assign link_wp = (`HAE_USER_MEM_BASE + link_boot_len + 32'h3) & ~32'h3;

  // reset-time analyse level, caught while reset is held
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      analyse_rst_r <= analyse_s;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      state_r <= ST_RESET;
    else
      case (state_r)
        ST_RESET:     state_r <= analyse_rst_r ? ST_AWAIT_LOW : ST_MEMCFG;
        ST_MEMCFG:    if (memcfg_done) state_r <= ST_REFRESH;
        ST_REFRESH:
          if (refresh_done && refresh_cnt_r == `HAE_INIT_REFRESH - 4'h1)
            state_r <= ST_BOOT;
        ST_AWAIT_LOW: if (!analyse_s) state_r <= ST_BOOT;
        ST_BOOT:      state_r <= bootsel_s ? ST_RUN : ST_WAIT_LINK;
        ST_WAIT_LINK: if (link_boot_done) state_r <= ST_RUN;
        ST_RUN:
          if (halt_fault)
            state_r <= ST_HALTED;
          else if (analyse_s)
            state_r <= ST_HALT_PEND;
        ST_HALT_PEND:
          if (halt_fault || desched_point || slice_timeout)
            state_r <= ST_HALTED;
        ST_HALTED:    state_r <= ST_HALTED;
        default:      state_r <= ST_RESET;
      endcase
  end

  // time slices counted while a halt is pending
  always_ff @(posedge mclk)
  begin
    if (!rstn || state_r != ST_HALT_PEND)
      slice_cnt_r <= 2'h0;
    else if (timeslice_tick && !hipri_active && slice_cnt_r != `HAE_HALT_SLICES)
      slice_cnt_r <= slice_cnt_r + 2'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn || state_r != ST_REFRESH)
      refresh_cnt_r <= 4'h0;
    else if (refresh_done)
      refresh_cnt_r <= refresh_cnt_r + 4'h1;
  end

  // flags survive a reset taken with analyse high
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      if (!analyse_s)
      begin
        fault_r <= 1'b0;
        hof_r   <= 1'b0;
        j0_r    <= 1'b0;
      end
    end
    else
    begin
      if (fault_set)
        fault_r <= 1'b1;
      else if (restore)
        fault_r <= saved_flags.fault;
      else if (fault_clr)
        fault_r <= 1'b0;
      if (restore)
        hof_r <= saved_flags.hof;
      else if (ctrl_wr)
        hof_r <= hwdata[`HAE_CTRL_HOF];
      if (ctrl_wr)
        j0_r <= hwdata[`HAE_CTRL_J0];
    end
  end

  // halt capture; kept through an analyse reset for post-mortem
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      if (!analyse_s)
      begin
        halt_ip_r     <= `HAE_ZERO_WORD;
        halt_wd_r     <= `HAE_ZERO_WORD;
        cause_fault_r <= 1'b0;
      end
    end
    else if (halt_fault)
    begin
      halt_ip_r     <= instr_ip + `HAE_IP_FAULT_STEP;
      halt_wd_r     <= {core_wp[31:1], core_pri};
      cause_fault_r <= 1'b1;
    end
    else if (state_r == ST_HALT_PEND && (desched_point || slice_timeout))
    begin
      halt_ip_r     <= instr_ip + `HAE_IP_HALT_STEP;
      halt_wd_r     <= {core_wp[31:1], core_pri};
      cause_fault_r <= 1'b0;
    end
  end

  // memory configuration is reused after an analyse reset
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      if (!analyse_s)
        cfg_valid_r <= 1'b0;
    end
    else if (state_r == ST_MEMCFG && memcfg_done)
      cfg_valid_r <= 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      memcfg_start <= 1'b0;
      init_refresh <= 1'b0;
      refresh_en   <= 1'b0;
    end
    else
    begin
      memcfg_start <= state_r == ST_RESET && !analyse_rst_r;
      init_refresh <= state_r == ST_REFRESH;
      refresh_en   <= cfg_valid_r;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      boot_go     <= 1'b0;
      boot_ip     <= `HAE_ZERO_WORD;
      boot_wp     <= `HAE_ZERO_WORD;
      stack_a     <= `HAE_ZERO_WORD;
      stack_b     <= `HAE_ZERO_WORD;
      stack_c     <= `HAE_ZERO_WORD;
      boot_link_r <= 2'h0;
      boot_rom_r  <= 1'b0;
    end
    else
    begin
      boot_go <= 1'b0;
      if ((state_r == ST_BOOT && bootsel_s) || (state_r == ST_WAIT_LINK && link_boot_done))
      begin
        boot_go    <= 1'b1;
        boot_rom_r <= state_r == ST_BOOT;
        stack_a    <= halt_ip_r;
        stack_b    <= halt_wd_r;
        if (state_r == ST_BOOT)
        begin
          boot_ip <= `HAE_ROM_BOOT_ADDR;
          boot_wp <= `HAE_USER_MEM_BASE;
          stack_c <= `HAE_ZERO_WORD;
        end
        else
        begin
          boot_ip     <= `HAE_USER_MEM_BASE;
          boot_wp     <= link_wp;
          stack_c     <= {30'h0, link_boot_id};
          boot_link_r <= link_boot_id;
        end
      end
    end
  end

  // chain input reaches nothing but the error pin and status bit 7
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      err_out <= 1'b0;
    else
      err_out <= fault_r | chain_s;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      proc_run               <= 1'b0;
      halted                 <= 1'b0;
      jump_zero_break_enable <= 1'b0;
      link_out_fetch_en      <= 1'b0;
      link_shutdown          <= 1'b0;
    end
    else
    begin
      proc_run               <= running;
      halted                 <= state_r == ST_HALTED;
      jump_zero_break_enable <= j0_r;
      link_out_fetch_en      <= running && !halt_fault;
      // links close only once every transfer in flight has drained
      link_shutdown <= state_r == ST_HALTED &&
                       ~|{link_stat.in_busy, link_stat.out_busy};
    end
  end

  // AHB-Lite: zero wait states, read data fetched in the address phase
  always_comb
  begin
    case (haddr[7:0])
      `HAE_OFF_STATUS:    rd_word = {21'h0, boot_rom_r, link_shutdown, cause_fault_r,
                                     chain_s, j0_r, hof_r, fault_r, state_r};
      `HAE_OFF_CTRL:      rd_word = {28'h0, j0_r, hof_r, 2'h0};
      `HAE_OFF_HALT_IP:   rd_word = halt_ip_r;
      `HAE_OFF_HALT_WD:   rd_word = halt_wd_r;
      `HAE_OFF_BOOT_IP:   rd_word = boot_ip;
      `HAE_OFF_BOOT_WP:   rd_word = boot_wp;
      `HAE_OFF_BOOT_LINK: rd_word = {30'h0, boot_link_r};
      default:            rd_word = `HAE_ZERO_WORD;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h0;
      hrdata    <= `HAE_ZERO_WORD;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend_r <= addr_phase && hwrite && hsize == 3'h2;
      wr_addr_r <= haddr[7:0];
      if (addr_phase && !hwrite)
        hrdata <= rd_word;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_err_or;
    rstn && $past(rstn) |-> err_out == $past(fault_r | chain_s);
  endproperty
  a_err_or: assert property (p_err_or) else $error("error pin is not fault or chain");

  property p_fault_sticky;
    fault_r && !fault_clr && !restore |=> fault_r;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault flag dropped");

  property p_hof_halt;
    state_r == ST_RUN && fault_set && !fault_r && hof_r |=> state_r == ST_HALTED ##1 halted;
  endproperty
  a_hof_halt: assert property (p_hof_halt) else $error("no halt on fault rise");

  property p_no_late_hof_halt;
    state_r == ST_RUN && fault_r && !analyse_s |=> state_r == ST_RUN;
  endproperty
  a_no_late_hof_halt: assert property (p_no_late_hof_halt) else $error("halted on old fault");

  property p_analyse_pend;
    state_r == ST_RUN && analyse_s && !halt_fault |=> state_r == ST_HALT_PEND;
  endproperty
  a_analyse_pend: assert property (p_analyse_pend) else $error("analyse not seen");

  property p_slice_bound;
    state_r == ST_HALT_PEND |-> slice_cnt_r < `HAE_HALT_SLICES;
  endproperty
  a_slice_bound: assert property (p_slice_bound) else $error("halt overran three slices");

  property p_refresh_halted;
    state_r == ST_HALTED && cfg_valid_r |=> refresh_en;
  endproperty
  a_refresh_halted: assert property (p_refresh_halted) else $error("refresh stopped");

  property p_fetch_off;
    state_r == ST_HALTED && $past(state_r) == ST_HALTED |-> !link_out_fetch_en;
  endproperty
  a_fetch_off: assert property (p_fetch_off) else $error("links fetch while halted");

  property p_analyse_skip;
    state_r == ST_RESET && analyse_rst_r |=> state_r == ST_AWAIT_LOW ##1 !memcfg_start;
  endproperty
  a_analyse_skip: assert property (p_analyse_skip) else $error("memory config not skipped");

  property p_flags_cleared;
    !$past(rstn) && !$past(analyse_s) |-> !hof_r && !j0_r && !fault_r;
  endproperty
  a_flags_cleared: assert property (p_flags_cleared) else $error("flags kept on reset");

  property p_halt_ip;
    state_r == ST_HALT_PEND && desched_point && !halt_fault
      |=> halt_ip_r == $past(instr_ip) + `HAE_IP_HALT_STEP;
  endproperty
  a_halt_ip: assert property (p_halt_ip) else $error("analyse halt ip wrong");

endmodule : hae_ctrl

// ==== testbench/hae_mem_model.sv ====
// memory-side responder: configuration handshake and the initial refresh burst
// assumes a one-cycle memcfg_start pulse and a level init_refresh from the controller
module hae_mem_model (
  // clock and pacing
  input  wire logic mclk,
  input  wire logic slow,
  // handshake with the controller
  input  wire logic memcfg_start,
  input  wire logic init_refresh,
  output logic      memcfg_done,
  output logic      refresh_done,
  // activity counts for the bench
  output int        cfg_count,
  output int        ref_count
);
  timeunit 1ns;
  timeprecision 100ps;
  int   cd;
  logic in_cfg;
  initial
  begin
    memcfg_done = 1'b0;
    refresh_done = 1'b0;
    cfg_count = 0;
    ref_count = 0;
    cd = 0;
    in_cfg = 1'b0;
  end
  always @(posedge mclk)
  begin
    memcfg_done <= 1'b0;
    refresh_done <= 1'b0;
    if (memcfg_start === 1'b1)
    begin
      cfg_count <= cfg_count + 1;
      in_cfg <= 1'b1;
      cd <= slow ? 9 : 2;
    end
    else if (cd > 1)
      cd <= cd - 1;
    else if (cd == 1)
    begin
      cd <= 0;
      in_cfg <= 1'b0;
      // a late refresh slot must never pose as a config answer
      if (in_cfg)
        memcfg_done <= 1'b1;
      else if (init_refresh === 1'b1)
      begin
        refresh_done <= 1'b1;
        ref_count <= ref_count + 1;
      end
    end
    else if (init_refresh === 1'b1)
      cd <= slow ? 6 : 2;
  end
endmodule : hae_mem_model

// ==== testbench/testbench.sv ====
// self-checking bench for the halt, analyse and error control block
// assumes hae_mem_model answers memory configuration and refresh
`include "hae_params.svh"
module testbench
  import hae_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0, rstn = 1'b0, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q, instr_ip, core_wp, boot_ip, boot_wp;
  logic [31:0] stack_a, stack_b, stack_c, link_boot_len, hip;
  logic [1:0] htrans, link_boot_id;
  logic [2:0] hsize, watch;
  logic analyse_halt, fault_chain_input, boot_source_select, err_out, slow;
  logic desched_point, timeslice_tick, hipri_active, core_pri, preempt_start;
  logic preempt_end, proc_run, halted, jzb, boot_go, memcfg_start, memcfg_done;
  logic init_refresh, refresh_done, refresh_en, link_boot_done, fetch_en, shut;
  hae_fault_src_t fault_src;
  hae_link_stat_t link_stat;
  int err_count = 0, total_checks = 0, cfg_count, ref_count, c, r;

  always #2.5 mclk = ~mclk;
  assign hready = hreadyout;
  assign watch = {shut, halted, boot_go};

  hae_ctrl i_dut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .analyse_halt(analyse_halt),
    .fault_chain_input(fault_chain_input), .boot_source_select(boot_source_select),
    .err_out(err_out), .desched_point(desched_point), .timeslice_tick(timeslice_tick),
    .hipri_active(hipri_active), .instr_ip(instr_ip), .core_wp(core_wp),
    .core_pri(core_pri), .fault_src(fault_src), .preempt_start(preempt_start),
    .preempt_end(preempt_end), .proc_run(proc_run), .halted(halted),
    .jump_zero_break_enable(jzb), .boot_go(boot_go), .boot_ip(boot_ip),
    .boot_wp(boot_wp), .stack_a(stack_a), .stack_b(stack_b), .stack_c(stack_c),
    .memcfg_start(memcfg_start), .memcfg_done(memcfg_done), .init_refresh(init_refresh),
    .refresh_done(refresh_done), .refresh_en(refresh_en), .link_stat(link_stat),
    .link_boot_done(link_boot_done), .link_boot_id(link_boot_id),
    .link_boot_len(link_boot_len), .link_out_fetch_en(fetch_en), .link_shutdown(shut));

  hae_mem_model i_mem (.mclk(mclk), .slow(slow), .memcfg_start(memcfg_start),
    .init_refresh(init_refresh), .memcfg_done(memcfg_done), .refresh_done(refresh_done),
    .cfg_count(cfg_count), .ref_count(ref_count));

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic give_up();
    err_count++;
    $display("MISMATCH t=%0t wait ran out", $time);
    final_report();
  endtask : give_up

  // sampled on the falling edge so design updates have landed
  task automatic wait_hi(input int i, input int lim);
    int n;
    n = 0;
    @(negedge mclk);
    while (watch[i] !== 1'b1 && n < lim)
    begin
      @(negedge mclk);
      n++;
    end
    if (watch[i] !== 1'b1)
      give_up();
    @(posedge mclk);
  endtask : wait_hi

  // one single word transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    hsize <= 3'b010;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hready !== 1'b1 && n < 100);
    if (n >= 100)
      give_up();
    q = hrdata;
    chk(hresp, 1'b0);
  endtask : ahb

  task automatic pulse_fault(input int i);
    fault_src <= hae_fault_src_t'(4'h1 << i);
    tick(1);
    fault_src <= '0;
    tick(3);
  endtask : pulse_fault

  task automatic analyse_reset();
    analyse_halt <= 1'b1;
    tick(8);
    rstn <= 1'b0;
    tick(12);
    rstn <= 1'b1;
    tick(10);
  endtask : analyse_reset

  initial
  begin
    void'($urandom(32'h56b9));
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {analyse_halt, fault_chain_input, desched_point, timeslice_tick} = '0;
    {hipri_active, preempt_start, preempt_end, link_boot_done} = '0;
    {fault_src, link_stat, link_boot_id, link_boot_len} = '0;
    boot_source_select = 1'b1;
    instr_ip = $urandom;
    core_wp = $urandom;
    core_pri = 1'($urandom);
    slow = 1'($urandom);
    tick(12);
    rstn <= 1'b1;
    wait_hi(0, 400);
    chk(cfg_count, 1);
    chk(ref_count, 8);
    chk(boot_ip, `HAE_ROM_BOOT_ADDR);
    chk(boot_wp, `HAE_USER_MEM_BASE);
    $display("test rom boot done");
    repeat (4)
    begin
      fault_chain_input <= 1'($urandom);
      tick(8);
      chk(err_out, fault_chain_input);
      ahb(1'b0, `HAE_OFF_STATUS, 0);
      chk(q[4], 1'b0);
    end
    fault_chain_input <= 1'b0;
    chk(proc_run, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      pulse_fault(i);
      chk(err_out, 1'b1);
      ahb(1'b1, `HAE_OFF_CTRL, 32'h2);
      ahb(1'b0, `HAE_OFF_STATUS, 0);
      chk(q[4], 1'b0);
    end
    preempt_start <= 1'b1;
    tick(1);
    preempt_start <= 1'b0;
    ahb(1'b1, `HAE_OFF_CTRL, 32'h1);
    preempt_end <= 1'b1;
    tick(1);
    preempt_end <= 1'b0;
    tick(3);
    chk(err_out, 1'b0);
    ahb(1'b1, `HAE_OFF_CTRL, 32'h1);
    ahb(1'b1, `HAE_OFF_CTRL, 32'h4);
    tick(10);
    chk(halted, 1'b0);
    ahb(1'b0, `HAE_OFF_STATUS, 0);
    chk(q[5:4], 2'b11);
    ahb(1'b1, `HAE_OFF_CTRL, 32'h2);
    ahb(1'b0, `HAE_OFF_STATUS, 0);
    chk(q[5:4], 2'b00);
    $display("test fault flag done");
    ahb(1'b1, `HAE_OFF_CTRL, 32'hc);
    // a link busy before the halt must hold shutdown off
    link_stat <= 8'h01;
    pulse_fault(int'($urandom % 4));
    wait_hi(1, 50);
    chk(refresh_en, 1'b1);
    hip = instr_ip + `HAE_IP_FAULT_STEP;
    ahb(1'b0, `HAE_OFF_HALT_IP, 0);
    chk(q, hip);
    tick(6);
    chk(shut, 1'b0);
    ahb(1'b0, `HAE_OFF_STATUS, 0);
    chk(q[9:8], 2'b01);
    link_stat <= '0;
    wait_hi(2, 20);
    $display("test fault halt done");
    boot_source_select <= 1'b0;
    c = cfg_count;
    r = ref_count;
    analyse_reset();
    ahb(1'b0, `HAE_OFF_STATUS, 0);
    chk(q[6:0], 7'h73);
    chk(jzb, 1'b1);
    analyse_halt <= 1'b0;
    tick(12);
    link_boot_id <= 2'($urandom);
    link_boot_len <= $urandom % 4096;
    link_boot_done <= 1'b1;
    tick(1);
    link_boot_done <= 1'b0;
    wait_hi(0, 50);
    chk(cfg_count, c);
    chk(ref_count, r);
    chk(boot_ip, `HAE_USER_MEM_BASE);
    chk(boot_wp, (`HAE_USER_MEM_BASE + link_boot_len + 3) & ~32'h3);
    chk(stack_a, hip);
    chk(stack_b, {core_wp[31:1], core_pri});
    chk(stack_c, {30'h0, link_boot_id});
    ahb(1'b0, `HAE_OFF_BOOT_LINK, 0);
    chk(q, {30'h0, link_boot_id});
    ahb(1'b1, `HAE_OFF_CTRL, 32'h2);
    $display("test link boot done");
    instr_ip <= $urandom;
    analyse_halt <= 1'b1;
    tick(8);
    ahb(1'b0, `HAE_OFF_STATUS, 0);
    chk(q[3:0], 4'h7);
    desched_point <= 1'b1;
    tick(1);
    desched_point <= 1'b0;
    wait_hi(1, 20);
    chk(fetch_en, 1'b0);
    chk(proc_run, 1'b0);
    chk(refresh_en, 1'b1);
    hip = instr_ip + `HAE_IP_HALT_STEP;
    boot_source_select <= 1'b1;
    analyse_reset();
    analyse_halt <= 1'b0;
    wait_hi(0, 50);
    chk(stack_a, hip);
    chk(boot_ip, `HAE_ROM_BOOT_ADDR);
    $display("test analyse halt done");
    analyse_halt <= 1'b1;
    tick(8);
    for (int i = 0; i < 4; i++)
    begin
      hipri_active <= (i == 2);
      timeslice_tick <= 1'b1;
      tick(1);
      timeslice_tick <= 1'b0;
      tick(3);
      if (i == 2)
        chk(halted, 1'b0);
    end
    hipri_active <= 1'b0;
    wait_hi(1, 20);
    $display("test time slice halt done");
    final_report();
  end
endmodule : testbench
